/* watchdog_consts.svh */
// constant definitions for the watchdog unit
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH
// register word indices (printed offsets not all multiples of four: index times four)
`define WD_CONTROL_IDX     8'h93
`define WD_RESTART_IDX     8'h94
`define WD_ADDR_W          10
// control field positions
`define WD_EN_BIT          7
`define WD_NMI_SEL_BIT     6
`define WD_RST_FLAG_BIT    5
`define WD_NMI_FLAG_BIT    4
`define WD_CLK_HI          3
`define WD_CLK_LO          2
`define WD_PER_HI          1
`define WD_PER_LO          0
// reset value of control, clock select 10b
`define WD_CLK_RESET       2'h2
`define WD_PER_RESET       2'h0
// clock select codes
`define WD_CLK_SYS         2'h0
`define WD_CLK_RTC         2'h1
`define WD_CLK_RC          2'h2
// time-out exponents, one per clock source and period code
`define WD_SH_SYS_0        5'h1B
`define WD_SH_SYS_1        5'h19
`define WD_SH_SYS_2        5'h16
`define WD_SH_SYS_3        5'h12
`define WD_SH_RTC_0        5'h11
`define WD_SH_RTC_1        5'h0E
`define WD_SH_RTC_2        5'h0B
`define WD_SH_RTC_3        5'h07
`define WD_SH_RC_0         5'h0F
`define WD_SH_RC_1         5'h0D
`define WD_SH_RC_2         5'h09
`define WD_SH_RC_3         5'h05
// restart keys
`define WD_KEY_FIRST       8'hA5
`define WD_KEY_SECOND      8'h5A
// counter width, covers 2^27
`define WD_CNT_W           28
// rc oscillator start-up time
`define WD_RC_START_MS     20
`define WD_CLK_HZ          20000000
// axi responses
`define WD_RESP_OKAY       2'h0
`define WD_RESP_SLVERR     2'h2
`endif

/* watchdog_pkg.sv */
// types shared by the watchdog unit
package watchdog_pkg;
   typedef struct packed {
      logic       enable;
      logic       nmi_sel;
      logic       rst_flag;
      logic       nmi_flag;
      logic [1:0] clk_sel;
      logic [1:0] period;
   } control_t;
   typedef enum logic {key_idle, key_armed} key_state_t;
endpackage

/* watchdog_unit.sv */
// watchdog unit with axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "watchdog_consts.svh"
module watchdog_unit #(
   parameter int unsigned RC_START_CYCLES = (`WD_RC_START_MS * (`WD_CLK_HZ / 1000))
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // reset cause from chip reset logic, sampled while aresetn is low
   input  wire logic        wd_reset_cause,
   input  wire logic        ext_nmi,
   input  wire logic        rtc_osc_tick,
   input  wire logic        line_freq_tick,
   input  wire logic        rtc_src_line,
   input  wire logic        rc_osc_tick,
   input  wire logic        rc_power_down_req,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             cpu_reset_req,
   output logic             wd_nmi,
   output logic             rc_osc_power_en
);
   localparam logic [`WD_ADDR_W-1:0] CTRL_ADDR = {`WD_CONTROL_IDX, 2'h0};
   localparam logic [`WD_ADDR_W-1:0] RST_ADDR  = {`WD_RESTART_IDX, 2'h0};

   watchdog_pkg::control_t   ctrl_r;
   watchdog_pkg::key_state_t key_r;
   logic [`WD_CNT_W-1:0]     cnt_r;
   logic [`WD_CNT_W-1:0]     limit;
   logic [31:0]              rc_wait_r;
   logic                     rc_ready_r;
   logic                     first_r;
   logic                     tick;
   logic                     timeout;
   logic                     restart;
   logic [`WD_ADDR_W-1:0]    awaddr_r;
   logic [7:0]               wbyte_r;
   logic                     aw_have_r;
   logic                     w_have_r;
   logic                     wr_fire;
   logic                     ctrl_wr;
   logic                     key_wr;

   // ************************************************************
   // time-out length
   // ************************************************************
   function automatic logic [`WD_CNT_W-1:0] period_count(input logic [1:0] src,
                                                        input logic [1:0] per);
      logic [4:0] sh;
      sh = 5'h0;
      unique case (src)
         `WD_CLK_SYS: begin
            unique case (per)
               2'h0: sh = `WD_SH_SYS_0;
               2'h1: sh = `WD_SH_SYS_1;
               2'h2: sh = `WD_SH_SYS_2;
               2'h3: sh = `WD_SH_SYS_3;
            endcase
         end
         `WD_CLK_RTC: begin
            unique case (per)
               2'h0: sh = `WD_SH_RTC_0;
               2'h1: sh = `WD_SH_RTC_1;
               2'h2: sh = `WD_SH_RTC_2;
               2'h3: sh = `WD_SH_RTC_3;
            endcase
         end
         `WD_CLK_RC: begin
            unique case (per)
               2'h0: sh = `WD_SH_RC_0;
               2'h1: sh = `WD_SH_RC_1;
               2'h2: sh = `WD_SH_RC_2;
               2'h3: sh = `WD_SH_RC_3;
            endcase
         end
         // reserved source: a zero limit keeps the time-out from ever firing
         default: begin
            sh = 5'h0;
         end
      endcase
      period_count = (sh == 5'h0) ? '0 : (`WD_CNT_W'(1) << sh);
   endfunction

   assign limit = period_count(ctrl_r.clk_sel, ctrl_r.period);

   // ************************************************************
   // register address decode
   // ************************************************************
   // low two address bits are ignored: every register is one aligned word
   function automatic logic is_reg(input logic [`WD_ADDR_W-1:0] addr,
                                   input logic [`WD_ADDR_W-1:0] target);
      is_reg = ({addr[`WD_ADDR_W-1:2], 2'h0} == target);
   endfunction

   // ************************************************************
   // counting clock selection
   // ************************************************************
   always_comb begin
      unique case (ctrl_r.clk_sel)
         `WD_CLK_SYS: tick = 1'b1;
         `WD_CLK_RTC: tick = rtc_src_line ? line_freq_tick : rtc_osc_tick;
         `WD_CLK_RC:  tick = rc_osc_tick & rc_ready_r;
         default:     tick = 1'b0;
      endcase
   end

   // rc oscillator stays powered while selected, whatever software asks
   assign rc_osc_power_en = (ctrl_r.clk_sel == `WD_CLK_RC) | ~rc_power_down_req;

   always_ff @(posedge aclk) begin
      if (!aresetn || !rc_osc_power_en) begin
         rc_wait_r  <= '0;
         rc_ready_r <= 1'b0;
      end else if (rc_wait_r >= RC_START_CYCLES - 1) begin
         rc_ready_r <= 1'b1;
      end else begin
         rc_wait_r  <= rc_wait_r + 32'h1;
      end
   end

   // ************************************************************
   // counter
   // ************************************************************
   assign timeout = ctrl_r.enable && tick && (limit != '0) && (cnt_r == limit - 1'b1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= '0;
      end else if (!ctrl_r.enable || restart || timeout) begin
         cnt_r <= '0;
      end else if (tick) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // both responses are one-cycle pulses; the far side stretches them as needed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_reset_req <= 1'b0;
      end else begin
         cpu_reset_req <= timeout & ~ctrl_r.nmi_sel;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wd_nmi <= 1'b0;
      end else begin
         wd_nmi <= timeout & ctrl_r.nmi_sel;
      end
   end

   // ************************************************************
   // restart key sequence
   // ************************************************************
   assign restart = key_wr && (key_r == watchdog_pkg::key_armed) &&
                    (wbyte_r == `WD_KEY_SECOND);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_r <= watchdog_pkg::key_idle;
      end else if (timeout) begin
         key_r <= watchdog_pkg::key_idle;
      end else if (key_wr) begin
         unique case (key_r)
            watchdog_pkg::key_idle:
               key_r <= (wbyte_r == `WD_KEY_FIRST) ? watchdog_pkg::key_armed
                                                   : watchdog_pkg::key_idle;
            watchdog_pkg::key_armed:
               key_r <= watchdog_pkg::key_idle;
         endcase
      end
   end

   // ************************************************************
   // control register
   // ************************************************************
   // the reset cause flag is caught on the first edge after release, never under reset itself
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   logic cause_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_r <= wd_reset_cause;
      end else begin
         cause_r <= cause_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r.enable  <= 1'b0;
         ctrl_r.nmi_sel <= 1'b0;
         ctrl_r.clk_sel <= `WD_CLK_RESET;
         ctrl_r.period  <= `WD_PER_RESET;
      end else if (ctrl_wr && !ctrl_r.enable) begin
         ctrl_r.enable  <= wbyte_r[`WD_EN_BIT];
         ctrl_r.nmi_sel <= wbyte_r[`WD_NMI_SEL_BIT];
         ctrl_r.clk_sel <= wbyte_r[`WD_CLK_HI:`WD_CLK_LO];
         ctrl_r.period  <= wbyte_r[`WD_PER_HI:`WD_PER_LO];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r.rst_flag <= 1'b0;
      end else if (first_r) begin
         ctrl_r.rst_flag <= cause_r;
      end else if (timeout && !ctrl_r.nmi_sel) begin
         ctrl_r.rst_flag <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r.nmi_flag <= 1'b0;
      end else if (timeout && ctrl_r.nmi_sel) begin
         ctrl_r.nmi_flag <= 1'b1;
      end else if (ext_nmi) begin
         ctrl_r.nmi_flag <= 1'b0;
      end
   end

   // ************************************************************
   // axi4-lite write side
   // ************************************************************
   assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
   assign wr_fire       = aw_have_r & w_have_r;
   assign ctrl_wr       = wr_fire && is_reg(awaddr_r, CTRL_ADDR);
   assign key_wr        = wr_fire && is_reg(awaddr_r, RST_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= '0;
         wbyte_r   <= 8'h00;
      end else if (wr_fire) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[`WD_ADDR_W-1:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            // a write without lane 0 counts as byte 00
            wbyte_r  <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WD_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (ctrl_wr || key_wr) ? `WD_RESP_OKAY : `WD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // axi4-lite read side
   // ************************************************************
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `WD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         if (is_reg(s_axi_araddr, CTRL_ADDR)) begin
            s_axi_rdata <= {24'h0, ctrl_r};
            s_axi_rresp <= `WD_RESP_OKAY;
         end else if (is_reg(s_axi_araddr, RST_ADDR)) begin
            // write-only register reads as zero
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `WD_RESP_OKAY;
         end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `WD_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // watchdog_unit

/* watchdog_chk.sv */
// assertion checker for the watchdog unit ports
`timescale 1ns/100ps
`include "watchdog_consts.svh"
module watchdog_chk #(
   parameter int unsigned RC_START_CYCLES = 10
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        rc_power_down_req,
   input wire logic [9:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        cpu_reset_req,
   input wire logic        wd_nmi,
   input wire logic        rc_osc_power_en
);
   logic rd_ctl_r;
   logic en_seen_r;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // an enable once read back may only vanish through a reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ctl_r  <= 1'b0;
         en_seen_r <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready)
            rd_ctl_r <= (s_axi_araddr == {`WD_CONTROL_IDX, 2'b00});
         if (s_axi_rvalid && s_axi_rready && rd_ctl_r && s_axi_rdata[7])
            en_seen_r <= 1'b1;
      end
   end
   chk_reset_pulse: assert property (cpu_reset_req |=> !cpu_reset_req)
      else $error("reset pulse too long");
   chk_nmi_pulse: assert property (wd_nmi |=> !wd_nmi)
      else $error("nmi pulse too long");
   chk_one_resp: assert property (!(cpu_reset_req && wd_nmi))
      else $error("reset and nmi together");
   chk_quiet_start: assert property ($rose(aresetn) |-> (!cpu_reset_req && !wd_nmi) [*8])
      else $error("time-out right after reset");
   chk_rc_power: assert property (!rc_power_down_req |-> rc_osc_power_en)
      else $error("rc oscillator powered down");
   chk_en_sticky: assert property (s_axi_rvalid && rd_ctl_r && en_seen_r |-> s_axi_rdata[7])
      else $error("enable bit cleared");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `WD_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   cover property (cpu_reset_req);
   cover property (wd_nmi);
   cover property (s_axi_rvalid && s_axi_rresp == `WD_RESP_SLVERR);
endmodule // watchdog_chk
bind watchdog_unit watchdog_chk #(.RC_START_CYCLES(RC_START_CYCLES)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .rc_power_down_req(rc_power_down_req),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .cpu_reset_req(cpu_reset_req), .wd_nmi(wd_nmi),
   .rc_osc_power_en(rc_osc_power_en));

/* watchdog_partner.sv */
// far-side model: clock sources and chip reset logic around the watchdog
`timescale 1ns/100ps
module watchdog_partner (
   input  wire logic aclk,
   input  wire logic por_n,
   input  wire logic cpu_reset_req,
   output logic      aresetn,
   output logic      wd_reset_cause,
   output logic      rtc_osc_tick,
   output logic      line_freq_tick,
   output logic      rc_osc_tick
);
   logic [3:0] div_r;
   logic [2:0] hold_r;
   // source rates scaled far up so time-outs stay short in simulation
   always_ff @(posedge aclk) begin
      if (!por_n) div_r <= 4'h0;
      else div_r <= (div_r == 4'hB) ? 4'h0 : div_r + 4'h1;
   end
   assign rtc_osc_tick   = (div_r[1:0] == 2'h0);
   assign line_freq_tick = (div_r == 4'h0);
   assign rc_osc_tick    = (div_r inside {4'h0, 4'h3, 4'h6, 4'h9});
   // a watchdog reset holds the chip down a few cycles and records its cause
   always_ff @(posedge aclk) begin
      if (!por_n) begin
         hold_r         <= 3'h0;
         wd_reset_cause <= 1'b0;
      end else if (cpu_reset_req) begin
         hold_r         <= 3'h4;
         wd_reset_cause <= 1'b1;
      end else if (hold_r != 3'h0) begin
         hold_r <= hold_r - 3'h1;
      end
   end
   assign aresetn = por_n && (hold_r == 3'h0);
endmodule // watchdog_partner

/* tb.sv */
// self-checking bench for the watchdog unit
`timescale 1ns/100ps
`include "watchdog_consts.svh"
module tb;
   localparam logic [9:0] CTL = {`WD_CONTROL_IDX, 2'b00};
   localparam logic [9:0] KEY = {`WD_RESTART_IDX, 2'b00};
   logic        aclk = 0, por_n = 0, ext_nmi = 0, src_line = 0, pd_req = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [9:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, got;
   logic [1:0]  bresp, rresp, resp;
   logic        aresetn, cause, rtc_t, line_t, rc_t, rst_req, nmi, pwr_en;
   logic        awready, wready, bvalid, arready, rvalid;
   int          mismatches = 0, num_checks = 0, cyc = 0, n;
   always #25 aclk = ~aclk;
   watchdog_partner far (.aclk(aclk), .por_n(por_n), .cpu_reset_req(rst_req),
      .aresetn(aresetn), .wd_reset_cause(cause), .rtc_osc_tick(rtc_t),
      .line_freq_tick(line_t), .rc_osc_tick(rc_t));
   watchdog_unit #(.RC_START_CYCLES(10)) dut (.aclk(aclk), .aresetn(aresetn),
      .wd_reset_cause(cause), .ext_nmi(ext_nmi), .rtc_osc_tick(rtc_t),
      .line_freq_tick(line_t), .rtc_src_line(src_line), .rc_osc_tick(rc_t),
      .rc_power_down_req(pd_req), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cpu_reset_req(rst_req), .wd_nmi(nmi), .rc_osc_power_en(pwr_en));
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_rng(input int g, input int lo, input int hi);
      num_checks++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("mismatch at %0t: %0d cycles to time-out", $time, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      got = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic restart();
      wr(KEY, `WD_KEY_FIRST);
      wr(KEY, `WD_KEY_SECOND);
   endtask
   // cycles until the chosen time-out pulse shows
   task automatic until_pulse(input bit want_nmi);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while ((want_nmi ? nmi : rst_req) !== 1'b1);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 12000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (10) @(posedge aclk);
      por_n <= 1'b1;
      rd(CTL); check(got, 32'h08);
      rd(10'h000); check({30'h0, resp}, {30'h0, `WD_RESP_SLVERR});
      wr(10'h000, 8'h00); check({30'h0, resp}, {30'h0, `WD_RESP_SLVERR});
      wr(CTL, 8'hC7); check({30'h0, resp}, {30'h0, `WD_RESP_OKAY});
      wr(CTL, 8'h00);
      rd(CTL); check(got, 32'hC7);
      wr(KEY, `WD_KEY_FIRST);
      repeat (200) @(posedge aclk);
      wr(KEY, `WD_KEY_SECOND);
      until_pulse(1'b1); check_rng(n, 500, 525);
      rd(CTL); check(got, 32'hD7);
      @(posedge aclk) ext_nmi <= 1'b1;
      @(posedge aclk) ext_nmi <= 1'b0;
      rd(CTL); check(got, 32'hC7);
      restart();
      repeat (300) @(posedge aclk);
      wr(KEY, `WD_KEY_FIRST);
      wr(KEY, 8'h3C);
      wr(KEY, `WD_KEY_SECOND);
      until_pulse(1'b1); check_rng(n, 170, 230);
      @(posedge aclk) por_n <= 1'b0;
      src_line <= 1'b1;
      pd_req <= 1'b1;
      repeat (3) @(posedge aclk);
      por_n <= 1'b1;
      rd(CTL); check(got, 32'h08);
      wr(CTL, 8'h87); check({31'h0, pwr_en}, 32'h0);
      restart();
      until_pulse(1'b0); check_rng(n, 1520, 1552);
      repeat (8) @(posedge aclk);
      rd(CTL); check(got, 32'h28);
      check({31'h0, pwr_en}, 32'h1);
      pd_req <= 1'b0;
      wr(CTL, 8'h8B);
      restart();
      until_pulse(1'b0); check_rng(n, 92, 104);
      repeat (8) @(posedge aclk);
      tally_and_finish();
   end
endmodule // tb
